// *** hdl/mie_defines.svh ***
/*
  Offsets, field positions, reset values and instruction codes of the
  instruction executor. Assumes a 32-bit Avalon-MM slave of eight words.
*/
`ifndef MIE_DEFINES_SVH
`define MIE_DEFINES_SVH

`define MIE_INSTR_W 14
`define MIE_PC_W 15
`define MIE_FILE_AW 12
`define MIE_AV_AW 5

// register byte offsets
`define MIE_REG_CTRL 5'h00
`define MIE_REG_STATUS 5'h04
`define MIE_REG_ACC 5'h08
`define MIE_REG_PC 5'h0C
`define MIE_REG_LATCH 5'h10
`define MIE_REG_PTR 5'h14
`define MIE_REG_BANK 5'h18
`define MIE_REG_WDT 5'h1C

// status field positions and reset values
`define MIE_ST_EXPIRED 4
`define MIE_ST_SLEPT 3
`define MIE_ST_ZERO 2
`define MIE_RST_FLAG_HI 1'b1

// file operand and indirect access
`define MIE_IND_F 7'h00
`define MIE_PTR_PROG_BIT 15

// extra instruction cycles
`define MIE_EXTRA_NONE 2'h0
`define MIE_EXTRA_ONE 2'h1

// instruction codes
`define MIE_OPC_CALL 3'h4
`define MIE_OPC_GOTO 3'h5
`define MIE_OPC_LITERAL_RETURN_OP 4'hD
`define MIE_OPC_BRA 5'h19
`define MIE_OPC_BCLR_SKIP 4'h6
`define MIE_OPC_BSET_SKIP 4'h7
`define MIE_OPC_INVERT 6'h09
`define MIE_OPC_MINUS1 6'h03
`define MIE_OPC_DECSKIP 6'h0B
`define MIE_OPC_INCSKIP 6'h0F
`define MIE_OPC_ZREG 7'h03
`define MIE_OPC_ZACC 7'h02
`define MIE_OPC_ACCUMULATOR_SUBROUTINE_JUMP 14'h000A
`define MIE_OPC_RETURN 14'h0008
`define MIE_OPC_RETINT 14'h0009
`define MIE_OPC_BRW 14'h000B
`define MIE_OPC_KICK 14'h0064

`endif

// *** hdl/mie_pkg.sv ***
/*
  Types of the instruction executor: phase enum and file request carrier.
  Assumes mie_defines.svh for widths.
*/
`include "mie_defines.svh"

package mie_pkg;

  typedef enum logic [1:0] {
    PH_FETCH = 2'b00,
    PH_LATCH = 2'b01,
    PH_READ = 2'b10,
    PH_EXEC = 2'b11
  } mie_phase_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [`MIE_FILE_AW-1:0] addr;
    logic [7:0] data;
  } mie_file_req_s;

endpackage

// *** hdl/mie_core.sv ***
/*
  Instruction executor of a small 8-bit core, with an Avalon-MM slave.
  Assumes program memory answers prog_data combinationally from
  prog_addr, and file memory answers file_rd_data combinationally
  while the read strobe is high; both on ref_clk.
*/
// Overview of operation
// RULE_01: other instructions take one instruction cycle
// RULE_02: both call forms take two cycles
// RULE_03: all three returns take two cycles
// RULE_04: jumps, branches and skips take two cycles
// RULE_05: indirect access to program memory adds cycle
// RULE_06: four clock periods per instruction cycle
// RULE_07: instruction words are fourteen bits wide
// RULE_08: file operands are always read before write
// RULE_09: file operand selects one of 128 registers
// RULE_10: destination bit picks accumulator or register
// RULE_11: literal call pushes, loads literal and latch
// RULE_12: accumulator call pushes, loads accumulator and latch
// RULE_13: watchdog kick zeroes counter, sets both flags
// RULE_14: invert register, destination select, zero flag
// RULE_15: minus one register, destination select, zero flag
// RULE_16: zero register and set zero flag
// RULE_17: zero accumulator and set zero flag
// RULE_18: zero flag set exactly when result zero
`timescale 1ns/100ps
`default_nettype none
`include "mie_defines.svh"

module mie_core #(
  parameter int STACK_DEPTH = 16,
  parameter int PRE_W = 7
) (
  input wire logic ref_clk,
  input wire logic reset,
  output logic [`MIE_PC_W-1:0] prog_addr_q,
  input wire logic [`MIE_INSTR_W-1:0] prog_data,
  output mie_pkg::mie_file_req_s file_req_q,
  input wire logic [7:0] file_rd_data,
  input wire logic [`MIE_AV_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  localparam int SP_W = $clog2(STACK_DEPTH);
  mie_pkg::mie_phase_e phase_q;
  logic [`MIE_INSTR_W-1:0] ir_q;
  logic [`MIE_PC_W-1:0] pc_q, pc_d, pc_inc, ret_head;
  logic [7:0] w_q, wdt_q, res;
  logic [PRE_W-1:0] pre_q;
  logic [6:0] latch_q;
  logic [15:0] ptr_q;
  logic [4:0] bank_q;
  logic [1:0] stall_q, extra;
  logic [SP_W-1:0] sp_q;
  logic [`MIE_PC_W-1:0] stack_mem [STACK_DEPTH];
  logic run_q, active_q, z_q, expired_q, slept_q;
  logic fetch_ok, exec, skip, wd_tick, timeout;
  logic op_call, op_accumulator_subroutine_jump, op_goto, op_bra, op_brw, op_ret, op_literal_return_op;
  logic op_retint, op_bclr, op_bset, op_decskip, op_incskip, op_invert;
  logic op_minus1, op_zreg, op_zacc, op_kick, uses_file, ind, two, to_acc;
  logic [6:0] fsel;
  logic [31:0] rd_mux;
  logic wr_ok;
  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction
  // decode of the held word; every operand sits inside the 14 bits
  assign fsel = ir_q[6:0]; // RULE_09
  assign op_call = ir_q[13:11] == `MIE_OPC_CALL; // RULE_07
  assign op_goto = ir_q[13:11] == `MIE_OPC_GOTO;
  assign op_literal_return_op = ir_q[13:10] == `MIE_OPC_LITERAL_RETURN_OP;
  assign op_bra = ir_q[13:9] == `MIE_OPC_BRA;
  assign op_bclr = ir_q[13:10] == `MIE_OPC_BCLR_SKIP;
  assign op_bset = ir_q[13:10] == `MIE_OPC_BSET_SKIP;
  assign op_invert = ir_q[13:8] == `MIE_OPC_INVERT;
  assign op_minus1 = ir_q[13:8] == `MIE_OPC_MINUS1;
  assign op_decskip = ir_q[13:8] == `MIE_OPC_DECSKIP;
  assign op_incskip = ir_q[13:8] == `MIE_OPC_INCSKIP;
  assign op_zreg = ir_q[13:7] == `MIE_OPC_ZREG;
  assign op_zacc = ir_q[13:7] == `MIE_OPC_ZACC;
  assign op_accumulator_subroutine_jump = ir_q == `MIE_OPC_ACCUMULATOR_SUBROUTINE_JUMP;
  assign op_ret = ir_q == `MIE_OPC_RETURN;
  assign op_retint = ir_q == `MIE_OPC_RETINT;
  assign op_brw = ir_q == `MIE_OPC_BRW;
  assign op_kick = ir_q == `MIE_OPC_KICK;
  assign uses_file = !op_zacc && (ir_q[13:12] == 2'h1 ||
    (ir_q[13:12] == 2'h0 && ir_q[11:8] != 4'h0));
  assign ind = uses_file && fsel == `MIE_IND_F &&
    ptr_q[`MIE_PTR_PROG_BIT];
  assign two = op_call | op_accumulator_subroutine_jump | op_ret | op_literal_return_op | op_retint |
    op_goto | op_bra | op_brw | op_bclr | op_bset | op_decskip |
    op_incskip;
  assign extra = {1'b0, two} + {1'b0, ind}; // RULE_01 RULE_05
  assign to_acc = !ir_q[7] &&
    (op_invert | op_minus1 | op_decskip | op_incskip); // RULE_10
  assign fetch_ok = active_q && stall_q == `MIE_EXTRA_NONE;
  assign exec = fetch_ok && phase_q == mie_pkg::PH_EXEC;
  assign pc_inc = pc_q + 15'h0001;
  assign ret_head = stack_mem[sp_q - 1'b1];
  always_comb begin
    res = file_rd_data;
    skip = 1'b0;
    if (op_invert) begin
      res = ~file_rd_data; // RULE_14
    end else if (op_minus1 || op_decskip) begin
      res = file_rd_data - 8'h01; // RULE_15
    end else if (op_incskip) begin
      res = file_rd_data + 8'h01;
    end else if (op_zreg || op_zacc) begin
      res = 8'h00; // RULE_16 RULE_17
    end
    if (op_decskip || op_incskip) begin
      skip = is_zero(res);
    end else if (op_bclr) begin
      skip = !file_rd_data[ir_q[9:7]];
    end else if (op_bset) begin
      skip = file_rd_data[ir_q[9:7]];
    end
  end
  always_comb begin
    pc_d = pc_inc;
    if (op_call || op_goto) begin
      pc_d = {latch_q[6:3], ir_q[10:0]}; // RULE_11
    end else if (op_accumulator_subroutine_jump) begin
      pc_d = {latch_q, w_q}; // RULE_12
    end else if (op_bra) begin
      pc_d = pc_inc + {{6{ir_q[8]}}, ir_q[8:0]};
    end else if (op_brw) begin
      pc_d = pc_inc + {7'h00, w_q};
    end else if (op_ret || op_literal_return_op || op_retint) begin
      pc_d = ret_head;
    end else if (skip) begin
      pc_d = pc_q + 15'h0002;
    end
  end
  // four clock periods make one instruction cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase_q <= mie_pkg::PH_FETCH;
    end else begin
      case (phase_q)
        mie_pkg::PH_FETCH: phase_q <= mie_pkg::PH_LATCH; // RULE_06
        mie_pkg::PH_LATCH: phase_q <= mie_pkg::PH_READ;
        mie_pkg::PH_READ: phase_q <= mie_pkg::PH_EXEC;
        mie_pkg::PH_EXEC: phase_q <= mie_pkg::PH_FETCH;
        default: phase_q <= mie_pkg::PH_FETCH;
      endcase
    end
  end
  // run changes only at a cycle boundary so no instruction is cut
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      active_q <= 1'b0;
    end else if (phase_q == mie_pkg::PH_EXEC) begin
      active_q <= run_q;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stall_q <= `MIE_EXTRA_NONE;
    end else if (exec) begin
      stall_q <= extra; // RULE_02 RULE_03 RULE_04
    end else if (phase_q == mie_pkg::PH_EXEC &&
        stall_q != `MIE_EXTRA_NONE) begin
      stall_q <= stall_q - `MIE_EXTRA_ONE;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prog_addr_q <= '0;
      ir_q <= '0;
    end else if (fetch_ok && phase_q == mie_pkg::PH_FETCH) begin
      prog_addr_q <= pc_q;
    end else if (fetch_ok && phase_q == mie_pkg::PH_LATCH) begin
      ir_q <= prog_data; // RULE_07
    end
  end
  // every file operand is read first, even by a pure write
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      file_req_q <= '0;
    end else begin
      file_req_q.rd <= 1'b0;
      file_req_q.wr <= 1'b0;
      if (fetch_ok && phase_q == mie_pkg::PH_READ && uses_file) begin
        file_req_q.rd <= 1'b1; // RULE_08
        file_req_q.addr <= fsel == `MIE_IND_F ?
          ptr_q[`MIE_FILE_AW-1:0] : {bank_q, fsel}; // RULE_09
      end else if (exec && uses_file && ir_q[13:12] == 2'h0 && ir_q[7]) begin
        file_req_q.wr <= 1'b1; // RULE_10 RULE_16
        file_req_q.data <= res;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pc_q <= '0;
    end else if (exec) begin
      pc_q <= pc_d;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (exec && (op_call || op_accumulator_subroutine_jump)) begin
      stack_mem[sp_q] <= pc_inc; // RULE_11 RULE_12
    end
  end
  // the stack wraps silently; overflow is software's concern
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sp_q <= '0;
    end else if (exec && (op_call || op_accumulator_subroutine_jump)) begin
      sp_q <= sp_q + 1'b1;
    end else if (exec && (op_ret || op_literal_return_op || op_retint)) begin
      sp_q <= sp_q - 1'b1; // RULE_03
    end
  end
  // core writes win over a bus write to the accumulator
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      w_q <= 8'h00;
    end else if (exec && op_literal_return_op) begin
      w_q <= ir_q[7:0];
    end else if (exec && (to_acc || op_zacc)) begin
      w_q <= res; // RULE_10 RULE_17
    end else if (wr_ok && avs_address == `MIE_REG_ACC) begin
      w_q <= avs_writedata[7:0];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      z_q <= 1'b0;
    end else if (exec && (op_invert || op_minus1 || op_zreg ||
        op_zacc)) begin
      z_q <= is_zero(res); // RULE_14 RULE_15 RULE_16 RULE_17 RULE_18
    end
  end
  assign wd_tick = active_q && phase_q == mie_pkg::PH_EXEC;
  assign timeout = wd_tick && &pre_q && &wdt_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pre_q <= '0;
      wdt_q <= 8'h00;
    end else if (exec && op_kick) begin
      pre_q <= '0; // RULE_13
      wdt_q <= 8'h00;
    end else if (wd_tick) begin
      pre_q <= pre_q + 1'b1;
      wdt_q <= &pre_q ? wdt_q + 8'h01 : wdt_q;
    end
  end
  // a kick and a timeout can fall in one cycle; the kick wins and sets both flags
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      expired_q <= `MIE_RST_FLAG_HI;
      slept_q <= `MIE_RST_FLAG_HI;
    end else if (exec && op_kick) begin
      expired_q <= 1'b1; // RULE_13
      slept_q <= 1'b1;
    end else if (timeout) begin
      expired_q <= 1'b0;
    end
  end
  // Avalon slave: one wait cycle, accepted when waitrequest is low
  assign wr_ok = avs_write && !avs_waitrequest;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `MIE_REG_CTRL: rd_mux = {31'h0, run_q};
      `MIE_REG_STATUS: begin
        rd_mux[`MIE_ST_EXPIRED] = expired_q;
        rd_mux[`MIE_ST_SLEPT] = slept_q;
        rd_mux[`MIE_ST_ZERO] = z_q;
      end
      `MIE_REG_ACC: rd_mux = {24'h0, w_q};
      `MIE_REG_PC: rd_mux = {17'h0, pc_q};
      `MIE_REG_LATCH: rd_mux = {25'h0, latch_q};
      `MIE_REG_PTR: rd_mux = {16'h0, ptr_q};
      `MIE_REG_BANK: rd_mux = {27'h0, bank_q};
      `MIE_REG_WDT: rd_mux = {24'h0, wdt_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= rd_mux;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      run_q <= 1'b0;
      latch_q <= 7'h00;
      ptr_q <= 16'h0000;
      bank_q <= 5'h00;
    end else if (wr_ok) begin
      case (avs_address)
        `MIE_REG_CTRL: run_q <= avs_writedata[0];
        `MIE_REG_LATCH: latch_q <= avs_writedata[6:0];
        `MIE_REG_PTR: ptr_q <= avs_writedata[15:0];
        `MIE_REG_BANK: bank_q <= avs_writedata[4:0];
        default: run_q <= run_q;
      endcase
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  phase_wrap_a: assert property ( // RULE_06
    phase_q == mie_pkg::PH_EXEC |=> phase_q == mie_pkg::PH_FETCH ##3
    phase_q == mie_pkg::PH_EXEC) else $error("phase not four clocks");
  single_cycle_a: assert property ( // RULE_01
    exec && !two && !ind |=> ##3 exec || !active_q)
    else $error("plain instruction not one cycle");
  call_two_a: assert property ( // RULE_02
    exec && (op_call || op_accumulator_subroutine_jump) && !ind |=> !exec [*7] ##1
    (exec || !active_q)) else $error("call not two cycles");
  ret_two_a: assert property ( // RULE_03
    exec && (op_ret || op_literal_return_op || op_retint) |=>
    sp_q == $past(sp_q) - 1'b1 && stall_q == `MIE_EXTRA_ONE)
    else $error("return not two cycles");
  branch_two_a: assert property ( // RULE_04
    exec && (op_goto || op_bra || op_brw || op_bset) && !ind |=>
    stall_q == `MIE_EXTRA_ONE) else $error("branch not two cycles");
  indirect_a: assert property ( // RULE_05
    exec && ind && !two |=> stall_q == `MIE_EXTRA_ONE)
    else $error("indirect cycle missing");
  rmw_read_a: assert property ( // RULE_08
    exec && uses_file |-> file_req_q.rd)
    else $error("file operand not read");
  call_target_a: assert property ( // RULE_11
    exec && op_call |=> pc_q == {$past(latch_q[6:3]),
    $past(ir_q[10:0])} && ret_head == $past(pc_inc))
    else $error("literal call target wrong");
  accumulator_subroutine_jump_target_a: assert property ( // RULE_12
    exec && op_accumulator_subroutine_jump |=> pc_q == {$past(latch_q), $past(w_q)})
    else $error("accumulator call target wrong");
  kick_flags_a: assert property ( // RULE_13
    exec && op_kick |=> wdt_q == 8'h00 && pre_q == '0 &&
    expired_q && slept_q) else $error("kick did not clear watchdog");
  zreg_a: assert property ( // RULE_16
    exec && op_zreg |=> z_q && file_req_q.wr &&
    file_req_q.data == 8'h00) else $error("register clear wrong");
  zacc_a: assert property ( // RULE_17
    exec && op_zacc |=> z_q && w_q == 8'h00)
    else $error("accumulator clear wrong");
  dest_acc_a: assert property ( // RULE_10
    exec && (op_invert || op_minus1) && !ir_q[7] |=>
    !file_req_q.wr && w_q == $past(res)) else $error("dest wrong");
  zero_flag_a: assert property ( // RULE_14 RULE_15 RULE_18
    exec && (op_invert || op_minus1) |=>
    z_q == ($past(res) == 8'h00)) else $error("zero flag wrong");

  call_c: cover property (exec && op_call);
  ret_c: cover property (exec && op_literal_return_op);
  kick_c: cover property (exec && op_kick);
  indirect_c: cover property (exec && ind);

endmodule
`default_nettype wire

// *** tb/mie_mem_model.sv ***
/*
  Program memory and file register space beside the executor.
  Assumes the core samples prog_data and file_rd_data combinationally.
*/
`timescale 1ns/100ps
`default_nettype none

module mie_mem_model (
  input wire logic ref_clk,
  input wire logic [14:0] prog_addr,
  output logic [13:0] prog_data,
  input wire mie_pkg::mie_file_req_s file_req,
  output logic [7:0] file_rd_data
);
  logic [13:0] rom [0:32767];
  logic [7:0] fmem [0:4095];
  logic rd_hit [0:4095];
  logic [7:0] last_q;

  assign prog_data = rom[prog_addr];
  // outside a read strobe the bus shows the inverse of the last byte
  assign file_rd_data = file_req.rd ? fmem[file_req.addr] : ~last_q;

  initial begin
    last_q = 8'h00;
    for (int i = 0; i < 32768; i++) rom[i] = 14'h0000;
    for (int i = 0; i < 4096; i++) begin
      fmem[i] = 8'h00;
      rd_hit[i] = 1'b0;
    end
  end

  always @(posedge ref_clk) begin
    if (file_req.rd === 1'b1) begin
      last_q <= fmem[file_req.addr];
      rd_hit[file_req.addr] <= 1'b1;
    end
    if (file_req.wr === 1'b1) fmem[file_req.addr] <= file_req.data;
  end
endmodule

`default_nettype wire

// *** tb/testbench.sv ***
/*
  Self-checking bench of the instruction executor: registers over
  Avalon-MM, a short program run from the memory model.
  Assumes mie_core and mie_mem_model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mie_defines.svh"

module testbench;
  logic ref_clk;
  logic reset;
  logic [14:0] prog_addr_q;
  logic [13:0] prog_data;
  mie_pkg::mie_file_req_s file_req_q;
  logic [7:0] file_rd_data;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int t_at [int];
  logic [14:0] prev_addr = 15'h0000;

  mie_core #(.STACK_DEPTH(16), .PRE_W(2)) u_dut (
    .ref_clk(ref_clk), .reset(reset), .prog_addr_q(prog_addr_q),
    .prog_data(prog_data), .file_req_q(file_req_q),
    .file_rd_data(file_rd_data), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  mie_mem_model u_mem (
    .ref_clk(ref_clk), .prog_addr(prog_addr_q), .prog_data(prog_data),
    .file_req(file_req_q), .file_rd_data(file_rd_data)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // clock count at which prog_addr_q last moved to each program address
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (prog_addr_q !== prev_addr) t_at[int'(prog_addr_q)] = cyc;
    prev_addr <= prog_addr_q;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask

  task automatic chk_gap(input int a, input int b, input int exp,
                         input string what);
    if (!t_at.exists(a) || !t_at.exists(b)) chk(32'h1, 32'h0, what);
    else chk(32'(t_at[b] - t_at[a]), 32'(exp), what);
  endtask

  // request held until the edge that samples waitrequest low
  task automatic av_access(input logic wr, input logic [4:0] a,
                           input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    // only the watchdog ends a wait that never sees waitrequest low
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic av_write(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    av_access(1'b1, a, d, q);
  endtask

  task automatic av_read_chk(input logic [4:0] a, input logic [31:0] exp,
                             input string what);
    logic [31:0] q;
    av_access(1'b0, a, 32'h0000_0000, q);
    chk(q, exp, what);
  endtask

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #20000;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    reset = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    av_read_chk(`MIE_REG_STATUS, 32'h0000_0018, "status reset");
    av_read_chk(`MIE_REG_ACC, 32'h0000_0000, "acc reset");
    av_read_chk(`MIE_REG_PC, 32'h0000_0000, "pc reset");
    av_read_chk(`MIE_REG_CTRL, 32'h0000_0000, "ctrl reset");
    av_read_chk(`MIE_REG_WDT, 32'h0000_0000, "wdt reset");
    av_read_chk(5'h03, 32'h0000_0000, "unmapped read");
    av_write(`MIE_REG_LATCH, 32'h0000_0009);
    av_write(`MIE_REG_PTR, 32'h0000_0040);
    av_write(`MIE_REG_BANK, 32'h0000_0001);
    av_read_chk(`MIE_REG_LATCH, 32'h0000_0009, "latch rw");
    av_read_chk(`MIE_REG_PTR, 32'h0000_0040, "ptr rw");
    av_read_chk(`MIE_REG_BANK, 32'h0000_0001, "bank rw");
    $display("test registers done");
    u_mem.fmem[12'h0A5] = 8'h77;
    u_mem.fmem[12'h0A6] = 8'hF0;
    u_mem.fmem[12'h0A8] = 8'h05;
    u_mem.fmem[12'h0FF] = 8'h01;
    u_mem.fmem[12'h040] = 8'h5A;
    u_mem.rom[15'h0000] = 14'h01A5;
    u_mem.rom[15'h0001] = 14'h09A6;
    u_mem.rom[15'h0002] = 14'h0328;
    u_mem.rom[15'h0003] = 14'h0064;
    u_mem.rom[15'h0004] = 14'h3201;
    u_mem.rom[15'h0006] = 14'h2010;
    u_mem.rom[15'h0007] = 14'h000A;
    u_mem.rom[15'h0008] = 14'h0980;
    u_mem.rom[15'h0009] = 14'h03FF;
    u_mem.rom[15'h000A] = 14'h33FF;
    u_mem.rom[15'h0810] = 14'h3430;
    u_mem.rom[15'h0930] = 14'h0100;
    u_mem.rom[15'h0931] = 14'h0008;
    av_write(`MIE_REG_CTRL, 32'h0000_0001);
    for (int i = 0; i < 600 && !t_at.exists(10); i++) @(posedge ref_clk);
    repeat (8) @(posedge ref_clk);
    av_write(`MIE_REG_CTRL, 32'h0000_0000);
    repeat (8) @(posedge ref_clk);
    chk_gap(1, 2, 4, "single cycle");
    chk_gap(2, 3, 4, "plain op");
    chk_gap(4, 6, 8, "jump");
    chk_gap(6, 12'h810, 8, "literal call");
    chk_gap(12'h810, 7, 8, "literal return");
    chk_gap(7, 12'h930, 8, "acc call");
    chk_gap(12'h931, 8, 8, "return");
    chk(32'(t_at.exists(12'h810)), 32'h1, "call target");
    chk(32'(u_mem.rd_hit[12'h0A5]), 32'h1, "read before clear");
    chk(32'(u_mem.fmem[12'h0A5]), 32'h0, "cleared reg");
    chk(32'(u_mem.fmem[12'h0A6]), 32'h0F, "inverted reg");
    chk(32'(u_mem.fmem[12'h0A8]), 32'h05, "dest acc keeps reg");
    chk(32'(u_mem.fmem[12'h0FF]), 32'h00, "bank reg minus one");
    chk(32'(u_mem.fmem[12'h040]), 32'hA5, "indirect invert");
    chk(32'(u_mem.fmem[12'h080]), 32'h00, "bank reg untouched");
    av_read_chk(`MIE_REG_ACC, 32'h0000_0000, "cleared acc");
    av_read_chk(`MIE_REG_STATUS, 32'h0000_001C, "flags");
    $display("test program done");
    end_of_test();
  end
endmodule

`default_nettype wire
